// ### dvfs_pkg.sv
// Behaviour
// - Sample the core wait-for-interrupt idle signal on every rising clock edge.
// - Average the idle stream over non-overlapping windows into a load level.
// - Multiply sixteen load inputs by their weights and add the products.
// - Software programs every load input weight.
// - Add the idle-based load and the weighted load into one figure.
// - Track load as an exponential moving average of the combined figure.
// - Compare the average with up and down thresholds, with separate flags.
// - Count consecutive up crossings and down crossings separately.
// - Raise an interrupt or DMA event when frequency must change.
// - Record load history into a log buffer for software analysis.
// - Raise an interrupt or DMA event once per programmed time quantum.
// - Drive both voltage select pins from two control register bits.
`default_nettype none
package dvfs_pkg;
	localparam int ADDR_W = 8;
	localparam int LOAD_W = 16;
	localparam int NUM_INPUTS = 16;
	localparam int WEIGHT_W = 8;
	localparam int CNT_W = 8;
	localparam int PREAVG_LOG2_DEF = 8;
	localparam int LOG_DEPTH_DEF = 16;

	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LIMIT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_QUANTUM = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_LOAD = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_POWER_CTRL0 = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_WEIGHT0 = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_LOG_INDEX = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_LOG_DATA = 8'h34;

	localparam int THR_DOWN_LSB = 0;
	localparam int THR_UP_LSB = 16;
	localparam int LIM_UP_LSB = 0;
	localparam int LIM_DOWN_LSB = 8;
	localparam int ST_UP_BIT = 0;
	localparam int ST_DOWN_BIT = 1;
	localparam int ST_QUANTUM_BIT = 2;
	localparam int ST_LOG_BIT = 3;
	localparam int ST_W = 4;
	localparam int LOAD_UP_BIT = 16;
	localparam int LOAD_DOWN_BIT = 17;
	localparam int LOG_WR_LSB = 8;
	localparam int VSEL_LSB = 0;

	localparam logic [31:0] CTRL_RST = 32'h0000_0010;
	localparam logic [31:0] THRESH_RST = 32'hC000_4000;
	localparam logic [31:0] LIMIT_RST = 32'h0000_0404;
	localparam logic [31:0] QUANTUM_RST = 32'h0001_0000;
	localparam logic [31:0] WEIGHT_RST = 32'h0000_0000;
	localparam logic [ST_W-1:0] MASK_RST = 4'h0;
	localparam logic [1:0] VSEL_RST = 2'h0;

	typedef struct packed {
		logic [2:0] ema_shift;
		logic dma_en;
		logic enable;
	} ctrl_s;

	typedef struct packed {
		logic up;
		logic down;
	} cross_s;

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction
endpackage
`default_nettype wire

// ### cross_counter.sv
`timescale 1ns/1ns
`default_nettype none
module cross_counter #(
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic strobe,
	input wire logic crossed,
	input wire logic [CW-1:0] limit,
	output logic [CW-1:0] count,
	output logic fire
);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic fire_ff;
	logic nxt_fire;

	generate
		if (CW < 1 || CW > 16)
		begin : g_chk
			$error("cross_counter width out of range");
		end
	endgenerate

	// Anything but a crossing, the opposite one included, breaks the run.
	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_fire = 1'b0;
		if (strobe)
		begin
			if (crossed)
			begin
				if (cnt_ff + 1'b1 >= limit)
				begin
					nxt_fire = 1'b1;
					nxt_cnt = '0;
				end
				else
				begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			else
			begin
				nxt_cnt = '0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_ff <= '0;
			fire_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			fire_ff <= nxt_fire;
		end
	end

	assign count = cnt_ff;
	assign fire = fire_ff;
endmodule // cross_counter
`default_nettype wire

// ### load_tracker.sv
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module load_tracker #(
	parameter int PREAVG_LOG2 = dvfs_pkg::PREAVG_LOG2_DEF,
	parameter int LOG_DEPTH = dvfs_pkg::LOG_DEPTH_DEF
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic CORE_WAIT_IDLE_SIGNAL,
	input wire logic [dvfs_pkg::NUM_INPUTS-1:0] LOAD_INPUTS,
	input wire logic [dvfs_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ,
	output logic DMA_REQ,
	output logic VOLTAGE_SELECT_PIN_0,
	output logic VOLTAGE_SELECT_PIN_1
);
	localparam int LW = $clog2(LOG_DEPTH);
	localparam int LW_W = dvfs_pkg::LOAD_W;

	generate
		if (PREAVG_LOG2 < 1 || PREAVG_LOG2 > 15 || LOG_DEPTH < 2
			|| LOG_DEPTH > 256 || (1 << LW) != LOG_DEPTH)
		begin : g_chk
			$error("load_tracker parameters out of range");
		end
	endgenerate

	dvfs_pkg::ctrl_s ctrl_ff, nxt_ctrl;
	logic [31:0] thresh_ff, nxt_thresh;
	logic [31:0] limit_ff, nxt_limit;
	logic [31:0] quantum_ff, nxt_quantum;
	logic [dvfs_pkg::ST_W-1:0] status_ff, nxt_status;
	logic [dvfs_pkg::ST_W-1:0] mask_ff, nxt_mask;
	logic [1:0] vsel_ff, nxt_vsel;
	logic [31:0] weight_ff [4];
	logic [31:0] nxt_weight [4];
	logic [31:0] rdata_ff, nxt_rdata;
	logic wait_ff, nxt_wait;
	logic irq_ff, nxt_irq;
	logic dma_ff, nxt_dma;
	logic [PREAVG_LOG2-1:0] win_ff, nxt_win;
	logic [PREAVG_LOG2:0] busy_ff, nxt_busy;
	logic [PREAVG_LOG2:0] busy_now;
	logic [LW_W-1:0] ema_ff, nxt_ema;
	logic upd_ff, nxt_upd;
	logic [31:0] qcnt_ff, nxt_qcnt;
	logic [LW-1:0] log_wr_ff, nxt_log_wr;
	logic [LW-1:0] log_rd_ff, nxt_log_rd;
	logic [LW_W-1:0] log_mem [LOG_DEPTH];
	logic acc;
	logic wr_acc;
	logic win_end;
	logic [11:0] wsum;
	logic [16:0] combined;
	logic [17:0] diff;
	logic [17:0] step;
	logic q_tick;
	dvfs_pkg::cross_s flag;
	dvfs_pkg::cross_s fire;
	logic [dvfs_pkg::ST_W-1:0] set_bits;
	logic [dvfs_pkg::ST_W-1:0] clr_bits;

	assign acc = (AVS_READ | AVS_WRITE) & wait_ff;
	assign wr_acc = acc & AVS_WRITE;
	assign win_end = ctrl_ff.enable & (&win_ff);

	// Weighted extra load, taken in the same cycle as the window closes.
	always_comb
	begin
		wsum = '0;
		for (int i = 0; i < dvfs_pkg::NUM_INPUTS; i++)
		begin
			if (LOAD_INPUTS[i])
			begin
				wsum = wsum + 12'(weight_ff[i/4][8*(i%4) +: 8]);
			end
		end
	end

	// Busy cycles in a window, scaled so a fully busy window is full scale.
	always_comb
	begin
		nxt_win = win_ff;
		nxt_busy = busy_ff;
		nxt_ema = ema_ff;
		// The last sample of a window still counts in that window.
		busy_now = busy_ff
			+ {{PREAVG_LOG2{1'b0}}, ~CORE_WAIT_IDLE_SIGNAL};
		combined = 17'(busy_now) << (16 - PREAVG_LOG2);
		combined = combined + 17'(wsum);
		if (combined[16])
		begin
			combined = 17'h0FFFF;
		end
		diff = {2'h0, combined[15:0]} - {2'h0, ema_ff};
		step = $signed(diff) >>> ctrl_ff.ema_shift;
		if (ctrl_ff.enable)
		begin
			nxt_win = win_ff + 1'b1;
			nxt_busy = busy_now;
			if (win_end)
			begin
				nxt_busy = '0;
				nxt_ema = LW_W'(ema_ff + step[15:0]);
			end
		end
		nxt_upd = win_end;
	end

	assign flag.up = ema_ff > thresh_ff[dvfs_pkg::THR_UP_LSB +: 16];
	assign flag.down = ema_ff < thresh_ff[dvfs_pkg::THR_DOWN_LSB +: 16];

	cross_counter #(.CW(dvfs_pkg::CNT_W)) u_up_cnt (
		.clk(REF_CLK),
		.srst(SRST),
		.strobe(upd_ff),
		.crossed(flag.up),
		.limit(limit_ff[dvfs_pkg::LIM_UP_LSB +: dvfs_pkg::CNT_W]),
		.count(),
		.fire(fire.up)
	);

	cross_counter #(.CW(dvfs_pkg::CNT_W)) u_down_cnt (
		.clk(REF_CLK),
		.srst(SRST),
		.strobe(upd_ff),
		.crossed(flag.down),
		.limit(limit_ff[dvfs_pkg::LIM_DOWN_LSB +: dvfs_pkg::CNT_W]),
		.count(),
		.fire(fire.down)
	);

	// A zero quantum stops the periodic event rather than firing every cycle.
	always_comb
	begin
		nxt_qcnt = qcnt_ff;
		q_tick = 1'b0;
		if (ctrl_ff.enable && quantum_ff != 32'h0000_0000)
		begin
			if (qcnt_ff + 32'h0000_0001 >= quantum_ff)
			begin
				q_tick = 1'b1;
				nxt_qcnt = '0;
			end
			else
			begin
				nxt_qcnt = qcnt_ff + 32'h0000_0001;
			end
		end
	end

	always_comb
	begin
		nxt_log_wr = log_wr_ff;
		if (upd_ff)
		begin
			nxt_log_wr = log_wr_ff + 1'b1;
		end
	end

	// Register access, status events and the interrupt and DMA outputs.
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		nxt_thresh = thresh_ff;
		nxt_limit = limit_ff;
		nxt_quantum = quantum_ff;
		nxt_mask = mask_ff;
		nxt_vsel = vsel_ff;
		nxt_weight = weight_ff;
		nxt_log_rd = log_rd_ff;
		nxt_rdata = rdata_ff;
		nxt_wait = 1'b1;
		clr_bits = '0;
		set_bits = '0;
		set_bits[dvfs_pkg::ST_UP_BIT] = fire.up;
		set_bits[dvfs_pkg::ST_DOWN_BIT] = fire.down;
		set_bits[dvfs_pkg::ST_QUANTUM_BIT] = q_tick;
		set_bits[dvfs_pkg::ST_LOG_BIT] = upd_ff & (&log_wr_ff);
		if (acc)
		begin
			nxt_wait = 1'b0;
			nxt_rdata = '0;
			case (AVS_ADDRESS)
			dvfs_pkg::OFS_CTRL:
			begin
				nxt_rdata = 32'(ctrl_ff);
				if (wr_acc)
				begin
					nxt_ctrl = dvfs_pkg::ctrl_s'(5'(dvfs_pkg::be_merge(
						32'(ctrl_ff), AVS_WRITEDATA, AVS_BYTEENABLE)));
				end
			end
			dvfs_pkg::OFS_THRESH:
			begin
				nxt_rdata = thresh_ff;
				if (wr_acc)
				begin
					nxt_thresh = dvfs_pkg::be_merge(thresh_ff, AVS_WRITEDATA,
						AVS_BYTEENABLE);
				end
			end
			dvfs_pkg::OFS_LIMIT:
			begin
				nxt_rdata = limit_ff;
				if (wr_acc)
				begin
					nxt_limit = dvfs_pkg::be_merge(limit_ff, AVS_WRITEDATA,
						AVS_BYTEENABLE) & 32'h0000_FFFF;
				end
			end
			dvfs_pkg::OFS_QUANTUM:
			begin
				nxt_rdata = quantum_ff;
				if (wr_acc)
				begin
					nxt_quantum = dvfs_pkg::be_merge(quantum_ff, AVS_WRITEDATA,
						AVS_BYTEENABLE);
				end
			end
			dvfs_pkg::OFS_STATUS:
			begin
				nxt_rdata = 32'(status_ff);
				if (wr_acc)
				begin
					clr_bits = dvfs_pkg::ST_W'(dvfs_pkg::be_merge(32'h0000_0000,
						AVS_WRITEDATA, AVS_BYTEENABLE));
				end
			end
			dvfs_pkg::OFS_MASK:
			begin
				nxt_rdata = 32'(mask_ff);
				if (wr_acc)
				begin
					nxt_mask = dvfs_pkg::ST_W'(dvfs_pkg::be_merge(32'(mask_ff),
						AVS_WRITEDATA, AVS_BYTEENABLE));
				end
			end
			dvfs_pkg::OFS_LOAD:
			begin
				nxt_rdata = 32'(ema_ff);
				nxt_rdata[dvfs_pkg::LOAD_UP_BIT] = flag.up;
				nxt_rdata[dvfs_pkg::LOAD_DOWN_BIT] = flag.down;
			end
			dvfs_pkg::OFS_POWER_CTRL0:
			begin
				nxt_rdata = 32'(vsel_ff);
				if (wr_acc && AVS_BYTEENABLE[0])
				begin
					nxt_vsel = AVS_WRITEDATA[dvfs_pkg::VSEL_LSB +: 2];
				end
			end
			dvfs_pkg::OFS_LOG_INDEX:
			begin
				nxt_rdata = 32'(log_rd_ff);
				nxt_rdata[dvfs_pkg::LOG_WR_LSB +: LW] = log_wr_ff;
				if (wr_acc && AVS_BYTEENABLE[0])
				begin
					nxt_log_rd = AVS_WRITEDATA[LW-1:0];
				end
			end
			dvfs_pkg::OFS_LOG_DATA:
			begin
				nxt_rdata = 32'(log_mem[log_rd_ff]);
				if (!AVS_WRITE)
				begin
					nxt_log_rd = log_rd_ff + 1'b1;
				end
			end
			default:
			begin
				for (int k = 0; k < 4; k++)
				begin
					if (AVS_ADDRESS == dvfs_pkg::OFS_WEIGHT0 + 8'(4 * k))
					begin
						nxt_rdata = weight_ff[k];
						if (wr_acc)
						begin
							nxt_weight[k] = dvfs_pkg::be_merge(weight_ff[k],
								AVS_WRITEDATA, AVS_BYTEENABLE);
						end
					end
				end
			end
			endcase
		end
		// Hardware events win over a software clear in the same cycle.
		nxt_status = (status_ff & ~clr_bits) | set_bits;
		nxt_irq = |(nxt_status & nxt_mask);
		// The incoming enable gates the request, so a disable acts at once.
		nxt_dma = nxt_ctrl.dma_en & (fire.up | fire.down | q_tick);
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			ctrl_ff <= dvfs_pkg::ctrl_s'(dvfs_pkg::CTRL_RST[4:0]);
			thresh_ff <= dvfs_pkg::THRESH_RST;
			limit_ff <= dvfs_pkg::LIMIT_RST;
			quantum_ff <= dvfs_pkg::QUANTUM_RST;
			status_ff <= '0;
			mask_ff <= dvfs_pkg::MASK_RST;
			vsel_ff <= dvfs_pkg::VSEL_RST;
			weight_ff <= '{default: dvfs_pkg::WEIGHT_RST};
			rdata_ff <= '0;
			wait_ff <= 1'b1;
			irq_ff <= 1'b0;
			dma_ff <= 1'b0;
			win_ff <= '0;
			busy_ff <= '0;
			ema_ff <= '0;
			upd_ff <= 1'b0;
			qcnt_ff <= '0;
			log_wr_ff <= '0;
			log_rd_ff <= '0;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			thresh_ff <= nxt_thresh;
			limit_ff <= nxt_limit;
			quantum_ff <= nxt_quantum;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			vsel_ff <= nxt_vsel;
			weight_ff <= nxt_weight;
			rdata_ff <= nxt_rdata;
			wait_ff <= nxt_wait;
			irq_ff <= nxt_irq;
			dma_ff <= nxt_dma;
			win_ff <= nxt_win;
			busy_ff <= nxt_busy;
			ema_ff <= nxt_ema;
			upd_ff <= nxt_upd;
			qcnt_ff <= nxt_qcnt;
			log_wr_ff <= nxt_log_wr;
			log_rd_ff <= nxt_log_rd;
		end
	end

	// The log is plain storage; its contents need no reset.
	always_ff @(posedge REF_CLK)
	begin
		if (upd_ff)
		begin
			log_mem[log_wr_ff] <= ema_ff;
		end
	end

	assign AVS_READDATA = rdata_ff;
	assign AVS_WAITREQUEST = wait_ff;
	assign IRQ = irq_ff;
	assign DMA_REQ = dma_ff;
	assign VOLTAGE_SELECT_PIN_0 = vsel_ff[0];
	assign VOLTAGE_SELECT_PIN_1 = vsel_ff[1];
endmodule // load_tracker
`default_nettype wire

// ### load_tracker_properties.sv
`timescale 1ns/1ns
`default_nettype none
module load_tracker_properties (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic [dvfs_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic IRQ,
	input wire logic DMA_REQ,
	input wire logic VOLTAGE_SELECT_PIN_0,
	input wire logic VOLTAGE_SELECT_PIN_1
);
	logic wr_done;
	logic [3:0] mask_ff;
	logic [3:0] nxt_mask;
	logic dma_en_ff;
	logic nxt_dma_en;
	// The slave takes a write on the edge where waitrequest still stands high.
	assign wr_done = AVS_WRITE && AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	always_comb
	begin
		nxt_mask = mask_ff;
		nxt_dma_en = dma_en_ff;
		if (wr_done && AVS_ADDRESS == dvfs_pkg::OFS_MASK)
			nxt_mask = AVS_WRITEDATA[3:0];
		if (wr_done && AVS_ADDRESS == dvfs_pkg::OFS_CTRL)
			nxt_dma_en = AVS_WRITEDATA[1];
	end
	always_ff @(posedge REF_CLK)
	begin
		mask_ff <= SRST ? 4'h0 : nxt_mask;
		dma_en_ff <= SRST ? 1'b0 : nxt_dma_en;
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	a_answer_next: assert property ((AVS_READ || AVS_WRITE) &&
		AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("answer late");
	a_low_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	a_low_cause: assert property (!AVS_WAITREQUEST |->
		$past(AVS_READ || AVS_WRITE)) else $error("answer without request");
	a_rdata_hold: assert property (!$stable(AVS_READDATA) |->
		!AVS_WAITREQUEST) else $error("read data moved while idle");
	a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST &&
		AVS_ADDRESS >= 8'h38 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	a_pins_follow: assert property (wr_done &&
		AVS_ADDRESS == dvfs_pkg::OFS_POWER_CTRL0 |=>
		{VOLTAGE_SELECT_PIN_1, VOLTAGE_SELECT_PIN_0} ==
		$past(AVS_WRITEDATA[1:0])) else $error("select pins wrong");
	a_pins_cause: assert property (!$stable({VOLTAGE_SELECT_PIN_1,
		VOLTAGE_SELECT_PIN_0}) |-> $past(AVS_WRITE))
		else $error("select pins moved without write");
	a_irq_masked: assert property ((mask_ff == 4'h0) [*2] |-> !IRQ)
		else $error("interrupt while all masked");
	a_dma_gated: assert property (DMA_REQ |-> dma_en_ff)
		else $error("dma request while disabled");
	c_pins_write: cover property (wr_done &&
		AVS_ADDRESS == dvfs_pkg::OFS_POWER_CTRL0);
	c_irq_rise: cover property ($rose(IRQ));
	c_dma_pulse: cover property (DMA_REQ);
endmodule // load_tracker_properties
bind load_tracker load_tracker_properties u_props (.REF_CLK(REF_CLK),
	.SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .DMA_REQ(DMA_REQ),
	.VOLTAGE_SELECT_PIN_0(VOLTAGE_SELECT_PIN_0),
	.VOLTAGE_SELECT_PIN_1(VOLTAGE_SELECT_PIN_1));
`default_nettype wire

// ### pmic_vsel_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmic_vsel_model (
	input wire logic supply_select_pin_0,
	input wire logic supply_select_pin_1,
	output logic [1:0] level
);
	// The supply picks one of four presets straight from the two pins.
	assign level = {supply_select_pin_1, supply_select_pin_0};
endmodule // pmic_vsel_model
`default_nettype wire

// ### load_tracker_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module load_tracker_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic idle = 1'b1;
	logic [15:0] ld_in = 16'h0000;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic wait_req;
	logic irq;
	logic dma;
	logic pin0;
	logic pin1;
	logic [1:0] level;
	logic [31:0] got;
	logic [31:0] w1;
	int num_errors = 0;
	int num_checks = 0;
	int dma_seen = 0;
	always #10 clk = ~clk;
	always @(posedge clk) if (dma === 1'b1) dma_seen <= dma_seen + 1;
	// A short window keeps the run brief; expectations assume 4 cycles.
	load_tracker #(.PREAVG_LOG2(2), .LOG_DEPTH(16)) u_dut (.REF_CLK(clk),
		.SRST(srst), .CORE_WAIT_IDLE_SIGNAL(idle), .LOAD_INPUTS(ld_in),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .IRQ(irq), .DMA_REQ(dma),
		.VOLTAGE_SELECT_PIN_0(pin0), .VOLTAGE_SELECT_PIN_1(pin1));
	pmic_vsel_model u_pmic (.supply_select_pin_0(pin0),
		.supply_select_pin_1(pin1), .level(level));
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wait_req !== 1'b0 && n < 50);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50)
		begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(got, e);
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rd_chk(dvfs_pkg::OFS_CTRL, dvfs_pkg::CTRL_RST);
		rd_chk(dvfs_pkg::OFS_THRESH, dvfs_pkg::THRESH_RST);
		rd_chk(dvfs_pkg::OFS_LIMIT, dvfs_pkg::LIMIT_RST);
		rd_chk(dvfs_pkg::OFS_QUANTUM, dvfs_pkg::QUANTUM_RST);
		rd_chk(dvfs_pkg::OFS_MASK, 32'h0);
		rd_chk(8'h40, 32'h0);
		for (int v = 0; v < 4; v++)
		begin
			bus(1'b1, dvfs_pkg::OFS_POWER_CTRL0, 32'(v));
			@(posedge clk);
			check({30'h0, level}, 32'(v));
		end
		be <= 4'h0;
		bus(1'b1, dvfs_pkg::OFS_POWER_CTRL0, 32'h1);
		be <= 4'hF;
		rd_chk(dvfs_pkg::OFS_POWER_CTRL0, 32'h3);
		bus(1'b1, dvfs_pkg::OFS_WEIGHT0 + 8'h04, 32'h0000_4000);
		bus(1'b1, dvfs_pkg::OFS_WEIGHT0 + 8'h0C, 32'h2000_0000);
		rd_chk(dvfs_pkg::OFS_WEIGHT0 + 8'h04, 32'h0000_4000);
		rd_chk(dvfs_pkg::OFS_WEIGHT0 + 8'h0C, 32'h2000_0000);
		bus(1'b1, dvfs_pkg::OFS_CTRL, 32'h0000_0013);
		repeat (40) @(posedge clk);
		bus(1'b0, dvfs_pkg::OFS_LOAD, 32'h0);
		check(got & 32'h3FFFF, 32'h20000);
		ld_in <= 16'h8020;
		repeat (600) @(posedge clk);
		bus(1'b0, dvfs_pkg::OFS_LOAD, 32'h0);
		// The average stalls up to 15 below its target with a shift of 4.
		check(32'(got[15:0] >= 16'h51 && got[15:0] <= 16'h60), 1);
		bus(1'b1, dvfs_pkg::OFS_MASK, 32'h1);
		ld_in <= 16'h0000;
		idle <= 1'b0;
		repeat (600) @(posedge clk);
		bus(1'b0, dvfs_pkg::OFS_LOAD, 32'h0);
		check(32'(got[17:16]), 32'h1);
		rd_chk(dvfs_pkg::OFS_STATUS, 32'hB);
		check(32'(irq), 32'h1);
		check(32'(dma_seen > 0), 32'h1);
		bus(1'b1, dvfs_pkg::OFS_STATUS, 32'h2);
		rd_chk(dvfs_pkg::OFS_STATUS, 32'h9);
		idle <= 1'b1;
		repeat (600) @(posedge clk);
		bus(1'b1, dvfs_pkg::OFS_STATUS, 32'h1);
		rd_chk(dvfs_pkg::OFS_STATUS, 32'hA);
		check(32'(irq), 32'h0);
		bus(1'b1, dvfs_pkg::OFS_MASK, 32'h2);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h1);
		bus(1'b1, dvfs_pkg::OFS_MASK, 32'h0);
		bus(1'b1, dvfs_pkg::OFS_QUANTUM, 32'd20);
		repeat (30) @(posedge clk);
		bus(1'b0, dvfs_pkg::OFS_STATUS, 32'h0);
		check(32'(got[2]), 32'h1);
		bus(1'b1, dvfs_pkg::OFS_QUANTUM, 32'h0);
		bus(1'b1, dvfs_pkg::OFS_STATUS, 32'h4);
		repeat (50) @(posedge clk);
		bus(1'b0, dvfs_pkg::OFS_STATUS, 32'h0);
		check(32'(got[2]), 32'h0);
		bus(1'b0, dvfs_pkg::OFS_LOG_INDEX, 32'h0);
		w1 = got;
		repeat (37) @(posedge clk);
		bus(1'b0, dvfs_pkg::OFS_LOG_INDEX, 32'h0);
		check(32'(4'(got[11:8] - w1[11:8])), 32'hA);
		bus(1'b0, dvfs_pkg::OFS_LOG_DATA, 32'h0);
		check(got, 32'h0);
		bus(1'b0, dvfs_pkg::OFS_LOG_INDEX, 32'h0);
		check(32'(4'(got[3:0] - w1[3:0])), 32'h1);
		finish_test();
	end
endmodule // load_tracker_tb_top
`default_nettype wire
